/* File: verilog/cpuc_timing.v */
// cpu timing control: clock divider, t-state sequencer, data bus cycles
`timescale 1ns/100ps
`include "cpuc_regs.vh"

// What this block does
// - divide select one halves clock, else direct
// - reset leaves divide select set, halved clock
// - reset clears cpu clock, rises second edge after
// - clearing divide select switches after instruction end
// - setting it returns after one or two t-states
// - instructions take two to four t-states
// - boundary clock rises at start, falls after address
// - two t-state: address mid first state
// - three t-state control: address mid intermediate state
// - data access: boundary falls end first, strobe mid
// - high byte mid first, low byte muxed
// - write: data on bus at last state, strobe low
// - read: bus floats, read strobe like write
// - long read adds second intermediate, later strobe
// - four t-state control: address mid second intermediate
// - two word instruction runs as two short
// - wait counts from control bits 4:3, 2:0
// - data waits only on data accesses
// - reset gives three, seven waits, long read off
// - instruction wait change delayed unless control type
// - data wait and long read apply immediately
// - waits before last state, counted concurrently
// - data waits are max of data, instruction minus one
module cpuc_timing (
    input  wire        mclk,
    input  wire        nrst,
    input  wire [3:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [3:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    input  wire [2:0]  instrType,
    input  wire        instrWrite,
    input  wire [15:0] dataAddr,
    input  wire [7:0]  wrData,
    input  wire        jumpTaken,
    input  wire [15:0] jumpAddr,
    output reg         instrDone,
    output reg  [7:0]  rdData,
    output reg         rdValid,
    output reg         cpuClk,
    output reg         instrBoundaryClk,
    output reg  [15:0] instrAddrBus,
    output reg  [7:0]  dataAddrHi,
    output reg         aleOut,
    output reg  [7:0]  adOut,
    output reg         adOeN,
    input  wire [7:0]  adIn,
    output reg         writeN,
    output reg         readN
);
    // ------------------------------------------------------------
    // states
    // ------------------------------------------------------------
    localparam [4:0] S_BOOT = 5'h01;
    localparam [4:0] S_T1   = 5'h02;
    localparam [4:0] S_TX   = 5'h04;
    localparam [4:0] S_TW   = 5'h08;
    localparam [4:0] S_T2   = 5'h10;

    reg  [7:0]  devCtl;
    reg  [7:0]  auxCtl;
    reg         awHeld;
    reg         wHeld;
    reg  [3:0]  awAddr;
    reg  [7:0]  wByte;
    reg         wLane;
    reg  [4:0]  state;
    reg         bootRel;
    reg         divEff;
    reg         ph;
    reg         tPar;
    reg  [1:0]  retCnt;
    reg  [1:0]  iwSnap;
    reg         secondWord;
    reg         curDm;
    reg         curWr;
    reg         curLong;
    reg         addrAtT1;
    reg         firstTx;
    reg  [1:0]  txLeft;
    reg  [2:0]  waitLeft;
    reg  [7:0]  wrLatch;
    wire [7:0]  adSync;

    // ------------------------------------------------------------
    // decode helpers
    // ------------------------------------------------------------
    function isMapped;
        input [3:0] a;
        begin
            isMapped = (a == `CPUC_OFS_DEVCTL) || (a == `CPUC_OFS_AUXCTL)
                    || (a == `CPUC_OFS_STATUS);
        end
    endfunction

    function [31:0] regRead;
        input [3:0] a;
        begin
            case (a)
                `CPUC_OFS_DEVCTL: regRead = {24'h000000, devCtl};
                `CPUC_OFS_AUXCTL: regRead = {24'h000000, auxCtl};
                `CPUC_OFS_STATUS: regRead = {instrAddrBus, 3'h0, state,
                                             7'h00, divEff};
                default:          regRead = 32'h00000000;
            endcase
        end
    endfunction

    // ------------------------------------------------------------
    // next instruction timing figures
    // ------------------------------------------------------------
    wire [2:0] ty   = secondWord ? `CPUC_TY_2T :
                      (instrType == `CPUC_TY_TWO) ? `CPUC_TY_2T :
                      instrType;
    wire       isPc = (ty == `CPUC_TY_PC3) || (ty == `CPUC_TY_PC4);
    wire       isDm = (ty == `CPUC_TY_DM) && !secondWord;
    // control types see the new count at once, others a step late
    wire [1:0] iwUse = isPc ? devCtl[`CPUC_DC_IW] : iwSnap;
    wire       longRd = isDm && !instrWrite
                        && auxCtl[`CPUC_AX_LONG];
    wire [2:0] dw    = devCtl[`CPUC_DC_DW];
    // the extra intermediate state of a long read counts as a data wait
    wire [2:0] dwEff = (longRd && dw != 3'h0) ? dw - 3'h1 :
                       longRd ? 3'h0 : dw;
    wire [2:0] iwM1  = (iwUse == 2'h0) ? 3'h0 :
                       {1'b0, iwUse - 2'h1};
    wire [2:0] waits = isDm ? ((dwEff > iwM1) ? dwEff : iwM1)
                            : {1'b0, iwUse};
    wire [1:0] txN   = (ty == `CPUC_TY_PC3) ? 2'h1 :
                       (ty == `CPUC_TY_PC4) ? 2'h2 :
                       isDm ? (longRd ? 2'h2 : 2'h1) : 2'h0;
    wire       tEnd  = !divEff || ph;
    wire       mid   = !divEff || !ph;
    wire       addrNow = (state == S_T1 && addrAtT1)
                      || (state == S_TX && !curDm && txLeft == 2'h0);
    wire [15:0] nextAddr = jumpTaken ? jumpAddr : instrAddrBus + 16'h0001;

    // ------------------------------------------------------------
    // data bus pin synchroniser
    // ------------------------------------------------------------
    cpuc_sync uSync (
        .mclk   (mclk),
        .nrst   (nrst),
        .pinIn  (adIn),
        .pinOut (adSync)
    );

    // ------------------------------------------------------------
    // axi4-lite write channel
    // ------------------------------------------------------------
    always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `CPUC_RESP_OK;
            awHeld        <= 1'b0;
            wHeld         <= 1'b0;
            awAddr        <= 4'h0;
            wByte         <= 8'h00;
            wLane         <= 1'b0;
            devCtl        <= `CPUC_DC_RST;
            auxCtl        <= `CPUC_AX_RST;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                awAddr        <= s_axi_awaddr;
                awHeld        <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wByte        <= s_axi_wdata[7:0];
                wLane        <= s_axi_wstrb[0];
                wHeld        <= 1'b1;
                s_axi_wready <= 1'b0;
            end
            // both halves held: store and answer
            if (awHeld && wHeld && !s_axi_bvalid) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= isMapped(awAddr) ? `CPUC_RESP_OK
                                                 : `CPUC_RESP_ERR;
                if (wLane && awAddr == `CPUC_OFS_DEVCTL) begin
                    devCtl <= wByte;
                end
                if (wLane && awAddr == `CPUC_OFS_AUXCTL) begin
                    auxCtl <= wByte;
                end
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                awHeld        <= 1'b0;
                wHeld         <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // axi4-lite read channel
    // ------------------------------------------------------------
    always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= `CPUC_RESP_OK;
        end else begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid  <= 1'b1;
                s_axi_rdata   <= regRead(s_axi_araddr);
                s_axi_rresp   <= isMapped(s_axi_araddr) ? `CPUC_RESP_OK
                                                        : `CPUC_RESP_ERR;
            end
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid  <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // clock generation and t-state sequencer
    // ------------------------------------------------------------
    always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            state            <= S_BOOT;
            bootRel          <= 1'b0;
            cpuClk           <= 1'b0;
            divEff           <= 1'b1;
            ph               <= 1'b0;
            tPar             <= 1'b0;
            retCnt           <= 2'h0;
            iwSnap           <= 2'h3;
            secondWord       <= 1'b0;
            curDm            <= 1'b0;
            curWr            <= 1'b0;
            curLong          <= 1'b0;
            addrAtT1         <= 1'b1;
            firstTx          <= 1'b0;
            txLeft           <= 2'h0;
            waitLeft         <= 3'h0;
            wrLatch          <= 8'h00;
            instrDone        <= 1'b0;
            rdData           <= 8'h00;
            rdValid          <= 1'b0;
            instrBoundaryClk <= 1'b0;
            instrAddrBus     <= 16'h0000;
            dataAddrHi       <= 8'h00;
            aleOut           <= 1'b0;
            adOut            <= 8'h00;
            adOeN            <= 1'b0;
            writeN           <= 1'b1;
            readN            <= 1'b1;
        end else begin
            instrDone <= 1'b0;
            rdValid   <= 1'b0;
            if (state == S_BOOT) begin
                // first edge lifts the clear, second starts t1
                bootRel <= 1'b1;
                if (bootRel) begin
                    cpuClk <= 1'b1;
                    ph     <= 1'b0;
                    state  <= S_T1;
                end
            end else begin
                // halved clock high in first half, else toggles once per t-state
                if (divEff) begin
                    ph     <= ~ph;
                    cpuClk <= ph;
                end else begin
                    cpuClk <= ~cpuClk;
                end
                // mid t-state actions
                if (mid) begin
                    if (addrNow) begin
                        instrAddrBus <= nextAddr;
                    end
                    if (state == S_T1 && curDm) begin
                        aleOut     <= 1'b1;
                        dataAddrHi <= dataAddr[15:8];
                        adOut      <= dataAddr[7:0];
                        adOeN      <= 1'b0;
                    end
                    if (state == S_TX && aleOut) begin
                        aleOut <= 1'b0;
                    end
                    if (state == S_TX && curLong && txLeft == 2'h0) begin
                        readN <= 1'b0;
                    end
                end
                // end of t-state actions
                if (tEnd) begin
                    if (!divEff) begin
                        tPar <= ~tPar;
                    end
                    if (addrNow) begin
                        instrBoundaryClk <= 1'b0;
                    end
                    if (state == S_TX && firstTx && curDm && !curWr) begin
                        adOeN <= 1'b1;
                    end
                    case (state)
                        S_T1: begin
                            firstTx <= 1'b1;
                            if (txLeft != 2'h0) begin
                                txLeft <= txLeft - 2'h1;
                                state  <= S_TX;
                            end else if (waitLeft != 3'h0) begin
                                state <= S_TW;
                            end else begin
                                state <= S_T2;
                            end
                        end
                        S_TX: begin
                            firstTx <= 1'b0;
                            if (txLeft != 2'h0) begin
                                txLeft <= txLeft - 2'h1;
                            end else if (waitLeft != 3'h0) begin
                                state <= S_TW;
                            end else begin
                                state <= S_T2;
                            end
                        end
                        S_TW: begin
                            waitLeft <= waitLeft - 3'h1;
                            if (waitLeft == 3'h1) begin
                                state <= S_T2;
                            end
                        end
                        S_T2: begin
                            state     <= S_T1;
                            instrDone <= 1'b1;
                            writeN    <= 1'b1;
                            readN     <= 1'b1;
                            adOeN     <= 1'b0;
                            if (curDm && !curWr) begin
                                rdData  <= adSync;
                                rdValid <= 1'b1;
                            end
                        end
                        default: begin
                            state <= S_T1;
                        end
                    endcase
                    // entry into the last state
                    if ((state == S_T1 && txLeft == 2'h0 && waitLeft == 3'h0)
                        || (state == S_TX && txLeft == 2'h0
                            && waitLeft == 3'h0)
                        || (state == S_TW && waitLeft == 3'h1)) begin
                        if (curDm && curWr) begin
                            writeN <= 1'b0;
                            adOut  <= wrLatch;
                        end
                        if (curDm && !curWr && !curLong) begin
                            readN <= 1'b0;
                        end
                    end
                    // switch to the undivided clock while it is low
                    if (state == S_T2 && divEff
                        && !devCtl[`CPUC_DC_DIV]) begin
                        divEff <= 1'b0;
                        tPar   <= 1'b0;
                    end
                    // return after one or two t-states, on a low clock
                    // phase so the cpu clock is never stretched high
                    if (state == S_T2 && !divEff && retCnt == 2'h0
                        && devCtl[`CPUC_DC_DIV]) begin
                        retCnt <= tPar ? 2'h2 : 2'h1;
                    end
                    if (retCnt != 2'h0) begin
                        retCnt <= retCnt - 2'h1;
                        if (retCnt == 2'h1) begin
                            divEff <= 1'b1;
                            ph     <= 1'b0;
                            cpuClk <= 1'b1;
                        end
                    end
                end
            end
            // load the next instruction at the start of t1
            if ((state == S_BOOT && bootRel)
                || (state == S_T2 && tEnd)) begin
                instrBoundaryClk <= 1'b1;
                secondWord <= !secondWord
                              && (instrType == `CPUC_TY_TWO);
                iwSnap     <= devCtl[`CPUC_DC_IW];
                curDm      <= isDm;
                curWr      <= instrWrite;
                curLong    <= longRd;
                addrAtT1   <= !isPc;
                txLeft     <= txN;
                waitLeft   <= waits;
                wrLatch    <= wrData;
            end
        end
    end
endmodule // cpuc_timing

/* File: verilog/cpuc_regs.vh */
// register map, field positions, reset values and instruction type codes
`ifndef CPUC_REGS_VH
`define CPUC_REGS_VH

// ------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------
`define CPUC_OFS_DEVCTL  4'h0
`define CPUC_OFS_AUXCTL  4'h4
`define CPUC_OFS_STATUS  4'h8

// ------------------------------------------------------------
// fields
// ------------------------------------------------------------
`define CPUC_DC_DW       2:0
`define CPUC_DC_IW       4:3
`define CPUC_DC_DIV      7
`define CPUC_AX_LONG     0

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define CPUC_DC_RST      8'h9f
`define CPUC_AX_RST      8'h00

// ------------------------------------------------------------
// instruction timing types
// ------------------------------------------------------------
`define CPUC_TY_2T       3'h0
`define CPUC_TY_PC3      3'h1
`define CPUC_TY_DM       3'h2
`define CPUC_TY_PC4      3'h3
`define CPUC_TY_TWO      3'h4

// ------------------------------------------------------------
// bus responses
// ------------------------------------------------------------
`define CPUC_RESP_OK     2'h0
`define CPUC_RESP_ERR    2'h2

`endif

/* File: verilog/cpuc_sync.v */
// three-stage pin synchroniser with agreement filter
`timescale 1ns/100ps
module cpuc_sync (
    input  wire       mclk,
    input  wire       nrst,
    input  wire [7:0] pinIn,
    output wire [7:0] pinOut
);
    genvar i;
    // ------------------------------------------------------------
    // one filter per bit
    // ------------------------------------------------------------
    generate
        for (i = 0; i < 8; i = i + 1) begin : gBit
            reg s1;
            reg s2;
            reg s3;
            reg q;
            // update only when second and third stage agree
            always @(posedge mclk or negedge nrst) begin
                if (!nrst) begin
                    s1 <= 1'b0;
                    s2 <= 1'b0;
                    s3 <= 1'b0;
                    q  <= 1'b0;
                end else begin
                    s1 <= pinIn[i];
                    s2 <= s1;
                    s3 <= s2;
                    if (s2 == s3) begin
                        q <= s3;
                    end
                end
            end
            // agreed value passes at once, held while stages differ
            assign pinOut[i] = (s2 == s3) ? s3 : q;
        end
    endgenerate
endmodule // cpuc_sync

/* File: verif/cpuc_timing_properties.sv */
// port assertions for the cpu timing block
`timescale 1ns/100ps
module cpuc_props (
    input wire        mclk,
    input wire        nrst,
    input wire        instrDone,
    input wire        rdValid,
    input wire        cpuClk,
    input wire        instrBoundaryClk,
    input wire [15:0] instrAddrBus,
    input wire        aleOut,
    input wire        adOeN,
    input wire        writeN,
    input wire        readN
);
    default clocking dck @(posedge mclk); endclocking
    default disable iff (!nrst);
    // ---------------------------------------
    // data bus cycle
    // ---------------------------------------
    strobe_excl_a: assert property (writeN || readN)
        else $error("both strobes low");
    write_drive_a: assert property (!writeN |-> !adOeN)
        else $error("bus floats under write strobe");
    read_float_a: assert property (!readN |-> adOeN)
        else $error("bus driven under read strobe");
    ale_quiet_a: assert property (aleOut |-> writeN && readN)
        else $error("strobe low while latch strobe high");
    // ---------------------------------------
    // instruction sequencing
    // ---------------------------------------
    done_pulse_a: assert property (instrDone |=> !instrDone)
        else $error("done longer than one cycle");
    read_end_a: assert property (rdValid |-> instrDone)
        else $error("read byte outside instruction end");
    addr_window_a: assert property ($changed(instrAddrBus) |->
        instrBoundaryClk || $past(instrBoundaryClk))
        else $error("address moved with boundary clock low");
    clk_high_a: assert property (cpuClk |=> !cpuClk)
        else $error("cpu clock high too long");
    cover property (rdValid);
    cover property ($fell(writeN));
    cover property ($fell(readN));
endmodule // cpuc_props

/* File: verif/cpuc_mem_model.sv */
// behavioural data memory on the multiplexed bus
`timescale 1ns/100ps
module cpuc_mem_model (
    input  wire       mclk,
    input  wire       aleOut,
    input  wire [7:0] dataAddrHi,
    input  wire [7:0] adOut,
    input  wire       adOeN,
    input  wire       writeN,
    output wire [7:0] adIn
);
    logic [7:0]  mem [0:65535];
    logic [15:0] addr = 16'h0000;
    logic        wrOld = 1'b1;
    // latch address while strobe high, store on write strobe rise
    always @(posedge mclk) begin
        if (aleOut) addr <= {dataAddrHi, adOut};
        if (writeN && !wrOld) mem[addr] <= adOut;
        wrOld <= writeN;
    end
    // memory answers while the device floats the bus
    assign adIn = adOeN ? mem[addr] : adOut;
endmodule // cpuc_mem_model

/* File: verif/cpu_timing_control_bus_cycles_tb_top.sv */
// self-checking bench for the cpu timing block
`timescale 1ns/100ps
`include "cpuc_regs.vh"
`define CHK(a, e) begin nCompared++; if ((a) !== (e)) begin failCount++; \
    $display("BAD %0t got %h want %h", $time, a, e); end end
module cpu_timing_control_bus_cycles_tb_top;
    logic mclk, nrst, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_rready, instrWrite;
    logic [3:0] s_axi_awaddr, s_axi_wstrb, s_axi_araddr;
    logic [31:0] s_axi_wdata, d;
    logic [2:0] instrType;
    logic [7:0] wrData, lastRd;
    logic [1:0] r;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    wire s_axi_rvalid, instrDone, rdValid, cpuClk, instrBoundaryClk;
    wire aleOut, adOeN, writeN, readN;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    wire [15:0] instrAddrBus;
    wire [7:0] rdData, dataAddrHi, adOut, adIn;
    int failCount = 0, nCompared = 0, cyc = 0;
    cpuc_timing i_dut (.*, .jumpTaken(1'b0), .jumpAddr(16'h0000),
        .dataAddr(16'h1234));
    cpuc_mem_model i_mem (.*);
    // clock and run limit
    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 20000) begin
            failCount++;
            summarize();
        end
    end
    task automatic summarize();
        if (failCount == 0 && nCompared > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // -----------------------------------------
    // bus and instruction drivers
    // -----------------------------------------
    task automatic axiWr(input logic [3:0] a, input logic [31:0] v);
        r = 2'bxx;
        @(posedge mclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (int n = 0; n < 100; n++) begin
            @(posedge mclk);
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid === 1'b1) begin
                r = s_axi_bresp;
                s_axi_bready <= 1'b0;
                break;
            end
        end
        if (r === 2'bxx) failCount++; // no write answer in time
    endtask
    task automatic axiRd(input logic [3:0] a);
        r = 2'bxx;
        d = 'x;
        @(posedge mclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (int n = 0; n < 100; n++) begin
            @(posedge mclk);
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid === 1'b1) begin
                d = s_axi_rdata;
                r = s_axi_rresp;
                s_axi_rready <= 1'b0;
                break;
            end
        end
        if (r === 2'bxx) failCount++; // no read answer in time
    endtask
    // time one instruction kind in mclk cycles, skipping stale ones
    task automatic runIns(input logic [2:0] ty, input logic wr, int len);
        int n;
        n = 0;
        lastRd = 8'hxx;
        @(posedge mclk);
        instrType <= ty;
        instrWrite <= wr;
        repeat (2) do @(posedge mclk); while (instrDone !== 1'b1 && ++n < 500);
        n = 0;
        do begin
            @(posedge mclk);
            n++;
            if (rdValid === 1'b1) lastRd = rdData;
        end while (instrDone !== 1'b1 && n < 500);
        `CHK(n, len)
    endtask
    // -----------------------------------------
    // scenarios
    // -----------------------------------------
    task automatic tRegs();
        axiRd(`CPUC_OFS_DEVCTL);
        `CHK(d, 32'h9f)
        axiRd(`CPUC_OFS_AUXCTL);
        `CHK(d, 32'h0)
        axiRd(`CPUC_OFS_STATUS);
        `CHK(d[0], 1'b1)
        axiRd(4'hc);
        `CHK(r, `CPUC_RESP_ERR)
        axiWr(4'hc, 32'h0);
        `CHK(r, `CPUC_RESP_ERR)
        s_axi_wstrb <= 4'h0;
        axiWr(`CPUC_OFS_DEVCTL, 32'h0);
        s_axi_wstrb <= 4'h1;
        axiRd(`CPUC_OFS_DEVCTL);
        `CHK(d, 32'h9f)
    endtask
    task automatic tTypes();
        runIns(`CPUC_TY_2T, 1'b0, 10);
        axiWr(`CPUC_OFS_DEVCTL, 32'h80);
        runIns(`CPUC_TY_2T, 1'b0, 4);
        runIns(`CPUC_TY_PC3, 1'b0, 6);
        runIns(`CPUC_TY_PC4, 1'b0, 8);
        runIns(`CPUC_TY_TWO, 1'b0, 4);
        runIns(`CPUC_TY_DM, 1'b1, 6);
        axiWr(`CPUC_OFS_DEVCTL, 32'h9b);
        runIns(`CPUC_TY_PC3, 1'b0, 12);
        runIns(`CPUC_TY_DM, 1'b1, 12);
        axiWr(`CPUC_OFS_DEVCTL, 32'h94);
        runIns(`CPUC_TY_DM, 1'b1, 14);
        runIns(`CPUC_TY_2T, 1'b0, 8);
    endtask
    task automatic tMem();
        wrData <= 8'ha5;
        axiWr(`CPUC_OFS_DEVCTL, 32'h83);
        runIns(`CPUC_TY_DM, 1'b1, 12);
        runIns(`CPUC_TY_DM, 1'b0, 12);
        `CHK(lastRd, 8'ha5)
        `CHK(dataAddrHi, 8'h12)
        axiWr(`CPUC_OFS_AUXCTL, 32'h1);
        axiWr(`CPUC_OFS_DEVCTL, 32'h80);
        runIns(`CPUC_TY_DM, 1'b0, 8);
        `CHK(lastRd, 8'ha5)
        axiWr(`CPUC_OFS_AUXCTL, 32'h0);
    endtask
    task automatic tClk();
        axiWr(`CPUC_OFS_DEVCTL, 32'h00);
        runIns(`CPUC_TY_2T, 1'b0, 2);
        axiRd(`CPUC_OFS_STATUS);
        `CHK(d[0], 1'b0)
        axiWr(`CPUC_OFS_DEVCTL, 32'h80);
        runIns(`CPUC_TY_2T, 1'b0, 4);
    endtask
    // reset, then the scenarios in turn
    initial begin
        nrst = 1'b0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
        {s_axi_arvalid, s_axi_rready, instrWrite} = 3'h0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 40'h0;
        s_axi_wstrb = 4'h1;
        instrType = `CPUC_TY_2T;
        wrData = 8'h00;
        repeat (8) @(posedge mclk);
        nrst <= 1'b1;
        tRegs();
        tTypes();
        tMem();
        tClk();
        summarize();
    end
endmodule // cpu_timing_control_bus_cycles_tb_top
bind cpuc_timing cpuc_props i_props (.mclk(mclk), .nrst(nrst),
    .instrDone(instrDone), .rdValid(rdValid), .cpuClk(cpuClk),
    .instrBoundaryClk(instrBoundaryClk), .instrAddrBus(instrAddrBus),
    .aleOut(aleOut), .adOeN(adOeN), .writeN(writeN), .readN(readN));
